// ### rtl/hdf_buffer.sv
// Notes on behaviour
// - One 512 by 8-bit buffer carries bytes between the host port and the internal command engine.
// - With the size select bit at 1 the usable capacity is 255 bytes.
// - At full capacity the fill count spans the fill register and two low bits of the control register.
// - The command engine may read or write the buffer while a command runs.
// - Writing 1 to the flush bit resets both pointers, zeroes the count and clears the error flag.
// - The fill count rises on every stored byte and falls on every byte read out.
// - In full mode the threshold takes bit 8 from control bit 2 (small mode forces it to 0) and bits 7 to 0 from the threshold register.
// - A write into a full buffer sets the error flag in the first interrupt status register.
// - The error flag stays set until a flush clears it.
// - One threshold sets both alerts, free space from the top and stored bytes from the bottom.
// - The almost-full flag is set when capacity minus fill count is at or below the threshold.
// - The almost-empty flag is set when the fill count is at or below the threshold.
// - With its enable set, a rise of the almost-empty flag drives the interrupt pin.
// - With its enable set, a rise of the almost-full flag drives the interrupt pin.
`timescale 1ns/1ps
`include "hdf_consts.svh"
module hdf_buffer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Host register port
    input wire hdf_pkg::hdf_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Command engine write stream
    input wire logic sm_wr_valid,
    input wire logic [7:0] sm_wr_data,
    output logic sm_wr_ready,
    // Command engine read
    input wire logic sm_rd_req,
    output logic sm_rd_ready,
    output logic [7:0] sm_rd_data,
    output logic sm_rd_valid,
    // Interrupt pin
    output logic irq
);
    logic [`HDF_AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [`HDF_CW-1:0] count_reg, count_next, cap;
    logic err_reg, err_next, size_reg, size_next;
    logic [8:0] thresh_reg, thresh_next, wm;
    logic hi_st_reg, hi_st_next, lo_st_reg, lo_st_next;
    logic hi_en_reg, hi_en_next, lo_en_reg, lo_en_next;
    logic hi_prev_reg, lo_prev_reg, irq_reg, irq_next;
    logic [7:0] rdata_reg, rdata_next, smd_reg, smd_next;
    logic smv_next, rvalid_next, hi_prev_next, lo_prev_next;
    logic rvalid_reg, smv_reg;
    logic host_wr, host_rd, flush_cmd, st_valid, st_ready, wr_en, rd_en;
    logic full, empty, wr_ok, rd_ok, overflow, sm_take;
    logic [7:0] st_data, wr_byte, ram_rdata, ctrl_rd, interrupt_status_first_rd;
    hdf_pkg::hdf_alert_t alert;

    // Unsigned less-or-equal on count width
    function automatic logic at_or_below(input logic [`HDF_CW-1:0] a, input logic [`HDF_CW-1:0] b);
        at_or_below = a <= b;
    endfunction : at_or_below

    // Access decode
    assign host_wr = reg_req.wr && reg_req.addr == `HDF_ADDR_DATA;
    assign host_rd = reg_req.rd && reg_req.addr == `HDF_ADDR_DATA;
    assign flush_cmd = reg_req.wr && reg_req.addr == `HDF_ADDR_CTRL && reg_req.wdata[`HDF_CTRL_FLUSH];

    // Engine write staging, stalls while host writes or flushes
    hdf_fifo #(.W(8), .D(`HDF_STAGE_DEPTH), .AW(4)) u_stage (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(sm_wr_valid),
        .in_ready(sm_wr_ready),
        .in_data(sm_wr_data),
        .out_valid(st_valid),
        .out_ready(st_ready),
        .out_data(st_data)
    );
    assign st_ready = !flush_cmd && !host_wr;

    // Shared storage for both directions
    hdf_ram #(.W(8), .D(`HDF_DEPTH), .AW(`HDF_AW)) u_ram (
        .clk(ref_clk),
        .we(wr_ok),
        .waddr(wr_ptr_reg),
        .wdata(wr_byte),
        .raddr(rd_ptr_reg),
        .rdata(ram_rdata)
    );

    // Port arbitration, host first, engine in the gaps
    assign wr_en = host_wr | (st_valid & st_ready);
    assign wr_byte = host_wr ? reg_req.wdata : st_data;
    assign sm_rd_ready = !host_rd && !flush_cmd;
    assign sm_take = sm_rd_req & sm_rd_ready;
    assign rd_en = host_rd | sm_take;

    // Capacity, full and empty
    assign cap = size_reg ? `HDF_CAP_SMALL : `HDF_CAP_FULL;
    assign full = count_reg >= cap;
    assign empty = count_reg == '0;
    assign wr_ok = wr_en & !full & !flush_cmd;
    assign overflow = wr_en & full & !flush_cmd;
    assign rd_ok = rd_en & !empty & !flush_cmd;

    // Shared threshold and both alerts
    assign wm = {thresh_reg[8] & !size_reg, thresh_reg[7:0]};
    assign alert.almost_full_flag = at_or_below(cap - count_reg, {1'b0, wm});
    assign alert.almost_empty_flag = at_or_below(count_reg, {1'b0, wm});

    // Pointer, count and error flag next values
    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        err_next = err_reg | overflow;
        if (flush_cmd) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            count_next = '0;
            err_next = 1'b0;
        end else begin
            if (wr_ok) begin
                wr_ptr_next = wr_ptr_reg + 1'b1;
            end
            if (rd_ok) begin
                rd_ptr_next = rd_ptr_reg + 1'b1;
            end
            count_next = count_reg + `HDF_CW'(wr_ok) - `HDF_CW'(rd_ok);
        end
    end

    // Configuration and interrupt next values
    always_comb begin
        size_next = size_reg;
        thresh_next = thresh_reg;
        hi_en_next = hi_en_reg;
        lo_en_next = lo_en_reg;
        hi_st_next = hi_st_reg;
        lo_st_next = lo_st_reg;
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                `HDF_ADDR_CTRL: begin
                    size_next = reg_req.wdata[`HDF_CTRL_SIZE];
                    thresh_next[8] = reg_req.wdata[`HDF_CTRL_WM_MSB];
                end
                `HDF_ADDR_THRESH: begin
                    thresh_next[7:0] = reg_req.wdata;
                end
                `HDF_ADDR_INTERRUPT_STATUS_FIRST: begin
                    hi_st_next = hi_st_reg & !reg_req.wdata[`HDF_IRQ_HI];
                    lo_st_next = lo_st_reg & !reg_req.wdata[`HDF_IRQ_LO];
                end
                `HDF_ADDR_INTERRUPT_ENABLE_FIRST: begin
                    hi_en_next = reg_req.wdata[`HDF_IRQ_HI];
                    lo_en_next = reg_req.wdata[`HDF_IRQ_LO];
                end
                default: begin
                end
            endcase
        end
        // Rising alerts latch, set wins over clear
        if (alert.almost_full_flag && !hi_prev_reg) begin
            hi_st_next = 1'b1;
        end
        if (alert.almost_empty_flag && !lo_prev_reg) begin
            lo_st_next = 1'b1;
        end
        irq_next = (hi_st_reg & hi_en_reg) | (lo_st_reg & lo_en_reg);
    end

    // Readback views
    assign ctrl_rd = {1'b0, size_reg, alert.almost_full_flag, alert.almost_empty_flag, 1'b0,
                      thresh_reg[8], count_reg[9:8]};
    assign interrupt_status_first_rd = {4'h0, lo_st_reg, hi_st_reg, err_reg, 1'b0};

    // Register read mux, unmapped reads zero
    always_comb begin
        rdata_next = 8'h00;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `HDF_ADDR_CTRL: rdata_next = ctrl_rd;
                `HDF_ADDR_THRESH: rdata_next = thresh_reg[7:0];
                `HDF_ADDR_FILL: rdata_next = count_reg[7:0];
                `HDF_ADDR_DATA: rdata_next = ram_rdata;
                `HDF_ADDR_INTERRUPT_STATUS_FIRST: rdata_next = interrupt_status_first_rd;
                `HDF_ADDR_INTERRUPT_ENABLE_FIRST: rdata_next = {4'h0, lo_en_reg, hi_en_reg, 2'b00};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Return strobes and alert history next values
    always_comb begin
        smd_next = sm_take ? ram_rdata : smd_reg;
        smv_next = sm_take;
        rvalid_next = reg_req.rd;
        hi_prev_next = alert.almost_full_flag;
        lo_prev_next = alert.almost_empty_flag;
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            err_reg <= 1'b0;
            size_reg <= `HDF_SIZE_RST;
            thresh_reg <= `HDF_THRESH_RST;
            hi_en_reg <= 1'b0;
            lo_en_reg <= 1'b0;
            hi_st_reg <= 1'b0;
            lo_st_reg <= 1'b0;
            hi_prev_reg <= 1'b1;
            lo_prev_reg <= 1'b1;
            irq_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            smd_reg <= 8'h00;
            smv_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            err_reg <= err_next;
            size_reg <= size_next;
            thresh_reg <= thresh_next;
            hi_en_reg <= hi_en_next;
            lo_en_reg <= lo_en_next;
            hi_st_reg <= hi_st_next;
            lo_st_reg <= lo_st_next;
            hi_prev_reg <= hi_prev_next;
            lo_prev_reg <= lo_prev_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            smd_reg <= smd_next;
            smv_reg <= smv_next;
        end
    end

    // Outputs
    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign sm_rd_data = smd_reg;
    assign sm_rd_valid = smv_reg;
    assign irq = irq_reg;

    // Checks
    a_flush_count_zero: assert property (@(posedge ref_clk) disable iff (reset)
        flush_cmd |=> count_reg == '0 && wr_ptr_reg == '0 && rd_ptr_reg == '0)
        else $error("flush left pointers or count nonzero");
    a_flush_err_clear: assert property (@(posedge ref_clk) disable iff (reset)
        flush_cmd |=> !err_reg)
        else $error("flush did not clear error flag");
    a_count_tracks_io: assert property (@(posedge ref_clk) disable iff (reset)
        !flush_cmd |=> count_reg == $past(count_reg) + `HDF_CW'($past(wr_ok)) - `HDF_CW'($past(rd_ok)))
        else $error("fill count does not follow writes and reads");
    a_overflow_sets_err: assert property (@(posedge ref_clk) disable iff (reset)
        host_wr && full && !rd_ok |=> err_reg)
        else $error("overflow did not set error flag");
    a_err_sticky_hold: assert property (@(posedge ref_clk) disable iff (reset)
        err_reg && !flush_cmd |=> err_reg)
        else $error("error flag dropped without flush");
    a_full_write_drop: assert property (@(posedge ref_clk) disable iff (reset)
        wr_en && full && !rd_en |=> $stable(count_reg) && $stable(wr_ptr_reg))
        else $error("write into full buffer changed state");
    a_empty_read_still: assert property (@(posedge ref_clk) disable iff (reset)
        rd_en && empty && !wr_en && !flush_cmd |=> count_reg == '0 && $stable(rd_ptr_reg))
        else $error("read from empty buffer changed state");
    a_capacity_bound: assert property (@(posedge ref_clk) disable iff (reset)
        count_reg <= cap)
        else $error("fill count above capacity");
    a_thresh_msb_write: assert property (@(posedge ref_clk) disable iff (reset)
        reg_req.wr && reg_req.addr == `HDF_ADDR_CTRL |=> thresh_reg[8] == $past(reg_req.wdata[`HDF_CTRL_WM_MSB]))
        else $error("threshold high bit not taken from control bit 2");
    a_lo_irq_pin: assert property (@(posedge ref_clk) disable iff (reset)
        (alert.almost_empty_flag && !lo_prev_reg && lo_en_reg) ##1 lo_en_reg |=> irq_reg)
        else $error("almost-empty rise did not raise interrupt");
    a_hi_irq_pin: assert property (@(posedge ref_clk) disable iff (reset)
        (alert.almost_full_flag && !hi_prev_reg && hi_en_reg) ##1 hi_en_reg |=> irq_reg)
        else $error("almost-full rise did not raise interrupt");
    a_fill_low_byte: assert property (@(posedge ref_clk) disable iff (reset)
        reg_req.rd && reg_req.addr == `HDF_ADDR_FILL |=> reg_rdata == $past(count_reg[7:0]))
        else $error("fill register does not show low count bits");
    a_fill_high_bits: assert property (@(posedge ref_clk) disable iff (reset)
        reg_req.rd && reg_req.addr == `HDF_ADDR_CTRL |=> reg_rdata[1:0] == $past(count_reg[9:8]))
        else $error("control register does not show high count bits");
    a_sm_read_return: assert property (@(posedge ref_clk) disable iff (reset)
        sm_take |=> sm_rd_valid && sm_rd_data == $past(ram_rdata))
        else $error("engine read did not return the stored byte");
    a_empty_lo_alert: assert property (@(posedge ref_clk) disable iff (reset)
        count_reg == '0 |-> alert.almost_empty_flag)
        else $error("empty buffer without almost-empty flag");
    a_full_hi_alert: assert property (@(posedge ref_clk) disable iff (reset)
        count_reg == cap |-> alert.almost_full_flag)
        else $error("full buffer without almost-full flag");
    c_overflow_seen: cover property (@(posedge ref_clk) disable iff (reset) overflow);
    c_flush_seen: cover property (@(posedge ref_clk) disable iff (reset) flush_cmd && count_reg != '0);
    c_hi_irq_seen: cover property (@(posedge ref_clk) disable iff (reset) hi_st_reg && hi_en_reg);
    c_engine_read: cover property (@(posedge ref_clk) disable iff (reset) sm_take && !empty);
    c_lo_irq_seen: cover property (@(posedge ref_clk) disable iff (reset) lo_st_reg && lo_en_reg);
endmodule : hdf_buffer

// ### shared/hdf_consts.svh
`ifndef HDF_CONSTS_SVH
`define HDF_CONSTS_SVH

// Register offsets
`define HDF_ADDR_CTRL 8'h02
`define HDF_ADDR_THRESH 8'h03
`define HDF_ADDR_FILL 8'h04
`define HDF_ADDR_DATA 8'h05
`define HDF_ADDR_INTERRUPT_STATUS_FIRST 8'h06
`define HDF_ADDR_INTERRUPT_ENABLE_FIRST 8'h08

// Control register fields
`define HDF_CTRL_FLUSH 7
`define HDF_CTRL_SIZE 6
`define HDF_CTRL_HI 5
`define HDF_CTRL_LO 4
`define HDF_CTRL_WM_MSB 2

// Interrupt status and enable fields
`define HDF_IRQ_ERR 1
`define HDF_IRQ_HI 2
`define HDF_IRQ_LO 3

// Buffer geometry
`define HDF_DEPTH 512
`define HDF_AW 9
`define HDF_CW 10
`define HDF_CAP_FULL 10'h200
`define HDF_CAP_SMALL 10'h0ff
`define HDF_STAGE_DEPTH 16

// Reset values
`define HDF_THRESH_RST 9'h008
`define HDF_SIZE_RST 1'b0

`endif

// ### shared/hdf_pkg.sv
package hdf_pkg;

    // One host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hdf_reg_req_t;

    // Alert pair from the shared threshold
    typedef struct packed {
        logic almost_full_flag;
        logic almost_empty_flag;
    } hdf_alert_t;

endpackage : hdf_pkg

// ### rtl/hdf_ram.sv
`timescale 1ns/1ps
module hdf_ram #(
    parameter int W = 8,
    parameter int D = 512,
    parameter int AW = 9
) (
    // Clock
    input wire logic clk,
    // Write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read side
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [D];

    // Storage write, no reset on contents
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read path, registered by the user
    assign rdata = mem[raddr];
endmodule : hdf_ram

// ### rtl/hdf_fifo.sv
`timescale 1ns/1ps
module hdf_fifo #(
    parameter int W = 8,
    parameter int D = 16,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // Handshake terms
    assign in_ready = cnt_reg != (AW+1)'(D);
    assign out_valid = cnt_reg != '0;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rp_reg];

    // Pointer and level next values
    always_comb begin
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end
endmodule : hdf_fifo

// ### verification/hdf_engine_model.sv
`timescale 1ns/1ps
module hdf_engine_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Byte stream into the buffer
    output logic sm_wr_valid,
    output logic [7:0] sm_wr_data,
    input wire logic sm_wr_ready,
    // Byte reads out of the buffer
    output logic sm_rd_req,
    input wire logic sm_rd_ready,
    input wire logic [7:0] sm_rd_data,
    input wire logic sm_rd_valid
);
    logic wr_rdy_seen;
    logic rd_rdy_seen;
    logic stall_seen;
    logic [7:0] got[$];

    // Idle request lines
    initial begin
        sm_wr_valid = 1'b0;
        sm_wr_data = 8'h00;
        sm_rd_req = 1'b0;
        stall_seen = 1'b0;
    end

    // Ready levels as the next rising edge will take them
    always @(negedge ref_clk) begin
        wr_rdy_seen = sm_wr_ready;
        rd_rdy_seen = sm_rd_ready;
        if (sm_wr_valid && !sm_wr_ready) stall_seen = 1'b1;
        if (sm_rd_valid === 1'b1) got.push_back(sm_rd_data);
    end

    // Stream n bytes, optionally pausing between them
    task automatic push(input int n, input logic [7:0] b, input int gap);
        for (int i = 0; i < n; i++) begin
            sm_wr_valid <= 1'b1;
            sm_wr_data <= b + 8'(i);
            do @(posedge ref_clk); while (!wr_rdy_seen);
            if (gap > 0 || i == n - 1) begin
                sm_wr_valid <= 1'b0;
                sm_wr_data <= ~sm_wr_data; // No stale byte on an idle line
                repeat (gap) @(posedge ref_clk);
            end
        end
    endtask : push

    // Request n bytes back to back
    task automatic pop(input int n);
        for (int i = 0; i < n; i++) begin
            sm_rd_req <= 1'b1;
            do @(posedge ref_clk); while (!rd_rdy_seen);
        end
        sm_rd_req <= 1'b0;
    endtask : pop
endmodule : hdf_engine_model

// ### verification/hdf_buffer_tb_top.sv
`timescale 1ns/1ps
`include "hdf_consts.svh"
module hdf_buffer_tb_top;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] exp;
    } hdf_row_t;
    logic ref_clk;
    logic reset;
    hdf_pkg::hdf_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic sm_wr_valid;
    logic [7:0] sm_wr_data;
    logic sm_wr_ready;
    logic sm_rd_req;
    logic sm_rd_ready;
    logic [7:0] sm_rd_data;
    logic sm_rd_valid;
    logic irq;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    hdf_row_t rows[7];

    hdf_buffer i_hdf_buffer (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sm_wr_valid(sm_wr_valid), .sm_wr_data(sm_wr_data), .sm_wr_ready(sm_wr_ready),
        .sm_rd_req(sm_rd_req), .sm_rd_ready(sm_rd_ready), .sm_rd_data(sm_rd_data), .sm_rd_valid(sm_rd_valid),
        .irq(irq));
    hdf_engine_model i_eng (.ref_clk(ref_clk), .reset(reset), .sm_wr_valid(sm_wr_valid),
        .sm_wr_data(sm_wr_data), .sm_wr_ready(sm_wr_ready), .sm_rd_req(sm_rd_req), .sm_rd_ready(sm_rd_ready),
        .sm_rd_data(sm_rd_data), .sm_rd_valid(sm_rd_valid));

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask : reg_wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        @(posedge ref_clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
        v = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
        chk8(what, exp, v);
    endtask : rd_chk

    task automatic fill(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) reg_wr(`HDF_ADDR_DATA, b + 8'(i));
    endtask : fill

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        reset = 1'b1;
        reg_req = '0;
        rows = '{'{8'h02, 8'h10}, '{8'h03, 8'h08}, '{8'h04, 8'h00}, '{8'h06, 8'h00},
            '{8'h08, 8'h00}, '{8'h07, 8'h00}, '{8'h01, 8'h00}};
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        // Reset values and unmapped offsets
        foreach (rows[i]) rd_chk("reset_reg", rows[i].addr, rows[i].exp);
        // Full mode, threshold 0x108, both alert interrupts enabled
        reg_wr(`HDF_ADDR_INTERRUPT_ENABLE_FIRST, 8'h0c);
        reg_wr(`HDF_ADDR_CTRL, 8'h04);
        rd_chk("ctrl_wm_msb", `HDF_ADDR_CTRL, 8'h14);
        fill(264, 8'h00);
        rd_chk("ctrl_264", `HDF_ADDR_CTRL, 8'h35);
        rd_chk("fill_264", `HDF_ADDR_FILL, 8'h08);
        fill(1, 8'h08);
        rd_chk("ctrl_265", `HDF_ADDR_CTRL, 8'h25);
        chk8("irq_hi", 8'h01, {7'h00, irq});
        rd_chk("interrupt_status_first_hi", `HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h04);
        fill(247, 8'h09);
        rd_chk("ctrl_512", `HDF_ADDR_CTRL, 8'h26);
        rd_chk("fill_512", `HDF_ADDR_FILL, 8'h00);
        // Overflow in full mode
        reg_wr(`HDF_ADDR_DATA, 8'hee);
        rd_chk("interrupt_status_first_ovf", `HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h06);
        rd_chk("ctrl_ovf", `HDF_ADDR_CTRL, 8'h26);
        reg_wr(`HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h06);
        idle(3);
        rd_chk("err_kept", `HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h02);
        chk8("irq_cleared", 8'h00, {7'h00, irq});
        rd_chk("first_byte", `HDF_ADDR_DATA, 8'h00);
        // Flush: empty again, error gone, almost-empty rises
        reg_wr(`HDF_ADDR_CTRL, 8'h80);
        idle(3);
        chk8("irq_lo", 8'h01, {7'h00, irq});
        rd_chk("interrupt_status_first_flush", `HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h08);
        rd_chk("ctrl_flush", `HDF_ADDR_CTRL, 8'h10);
        rd_chk("fill_flush", `HDF_ADDR_FILL, 8'h00);
        reg_wr(`HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h08);
        // Small mode limits at 255
        reg_wr(`HDF_ADDR_CTRL, 8'hc0);
        fill(246, 8'h00);
        rd_chk("small_246", `HDF_ADDR_CTRL, 8'h40);
        fill(1, 8'h00);
        rd_chk("small_247", `HDF_ADDR_CTRL, 8'h60);
        fill(8, 8'h00);
        rd_chk("small_full", `HDF_ADDR_FILL, 8'hff);
        reg_wr(`HDF_ADDR_DATA, 8'hee);
        rd_chk("small_ovf", `HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h06);
        rd_chk("small_kept", `HDF_ADDR_FILL, 8'hff);
        reg_wr(`HDF_ADDR_CTRL, 8'h80);
        reg_wr(`HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h0e);
        // Engine writes with pauses, host reads them after it finishes
        i_eng.push(5, 8'h30, 3);
        idle(6);
        rd_chk("eng_fill", `HDF_ADDR_FILL, 8'h05);
        for (int i = 0; i < 5; i++) rd_chk("eng_byte", `HDF_ADDR_DATA, 8'h30 + 8'(i));
        // Engine reads host bytes, one read past empty
        fill(3, 8'ha0);
        i_eng.pop(4);
        idle(3);
        for (int i = 0; i < 3; i++) chk8("eng_read", 8'ha0 + 8'(i), i_eng.got[i]);
        rd_chk("empty_read", `HDF_ADDR_FILL, 8'h00);
        // Host burst blocks staging drain until it refuses
        fork
            begin
                @(posedge ref_clk);
                reg_req <= '{1'b1, 1'b0, `HDF_ADDR_DATA, 8'h5a};
                repeat (20) @(posedge ref_clk);
                reg_req <= '0;
            end
            i_eng.push(24, 8'h40, 0);
        join
        idle(40);
        chk8("staging_full", 8'h01, {7'h00, i_eng.stall_seen});
        rd_chk("burst_fill", `HDF_ADDR_FILL, 8'h2c);
        i_eng.pop(44);
        idle(3);
        rd_chk("drained", `HDF_ADDR_FILL, 8'h00);
        // Mid-run reset drops contents, status and pin
        fill(4, 8'h11);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd_chk("rst_fill", `HDF_ADDR_FILL, 8'h00);
        rd_chk("rst_ctrl", `HDF_ADDR_CTRL, 8'h10);
        rd_chk("rst_interrupt_status_first", `HDF_ADDR_INTERRUPT_STATUS_FIRST, 8'h00);
        chk8("rst_irq", 8'h00, {7'h00, irq});
        wrap_up();
    end
endmodule : hdf_buffer_tb_top
